/* logic/wdl_defs.vh */
// Constants for the word decrement, loop and interrupt disable execution block
`ifndef WDL_DEFS_VH
`define WDL_DEFS_VH
`define WDL_OP_WORD_DEC_PAIR 8'h80
`define WDL_OP_WORD_DEC_IND 8'h81
`define WDL_OP_INT_DISABLE 8'h8f
`define WDL_OP_LOOP_LOW 4'ha
`define WDL_WREG_NIBBLE 4'he
`define WDL_IMR_ADDR 8'hfb
`define WDL_IMR_GLOBAL_BIT 7
`define WDL_CYC_WORD_DEC 4'd10
`define WDL_CYC_INT_DISABLE 4'd6
`define WDL_CYC_LOOP_TAKEN 4'd12
`define WDL_CYC_LOOP_FALL 4'd10
`define WDL_FLAG_C 7
`define WDL_FLAG_Z 6
`define WDL_FLAG_S 5
`define WDL_FLAG_V 4
`define WDL_FLAG_D 3
`define WDL_FLAG_H 2
`define WDL_RP_RESET 4'h0
`define WDL_IMR_RESET 8'h00
`define WDL_FLAGS_RESET 8'h00
`endif

/* logic/wdl_regfile.v */
// Byte-wide register file with registered read data
`timescale 1ns/1ps
module wdl_regfile (
  input wire mclk_in,
  input wire we_in,
  input wire [7:0] waddr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] raddr_in,
  output reg [7:0] rdata_out
);
  reg [7:0] mem [0:255];
  always @(posedge mclk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule // wdl_regfile

/* logic/wdl_exec.v */
// Execution of word decrement, interrupt disable and count loop branch instructions
//
// How it works
// - Word decrement: 16-bit minus one, ten cycles
// - Zero flag set when 16-bit result zero
// - Overflow flag on signed 16-bit overflow
// - Sign flag follows result bit fifteen
// - Carry, half-carry, decimal-adjust flags untouched
// - Operand Ex selects working register pair
// - Interrupt disable clears mask bit seven, six cycles
// - Per-level mask enables stay unchanged
// - Loop opcode rA; twelve or ten cycles
// - Decrement register; branch when result nonzero
// - Displacement added to next instruction address
// - Displacement signed, range -128 to +127
// - Counter valid only in 04 to 7F
`timescale 1ns/1ps
`include "wdl_defs.vh"
module wdl_exec (
  input wire mclk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire [7:0] opcode_in,
  input wire [7:0] operand_in,
  input wire [15:0] next_pc_in,
  input wire [3:0] reg_ptr_in,
  input wire rf_we_in,
  input wire [7:0] rf_waddr_in,
  input wire [7:0] rf_wdata_in,
  input wire [7:0] flags_in,
  input wire flags_we_in,
  input wire [7:0] imr_in,
  input wire imr_we_in,
  output wire busy_out,
  output reg done_out,
  output reg [15:0] pc_out,
  output reg pc_load_out,
  output reg [7:0] flags_out,
  output reg [7:0] interrupt_mask_reg_out,
  output reg [3:0] cycles_out,
  output reg illegal_out
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 8'b00000001;
  localparam ST_PTR = 8'b00000010;
  localparam ST_RDHI = 8'b00000100;
  localparam ST_RDLO = 8'b00001000;
  localparam ST_WRHI = 8'b00010000;
  localparam ST_WRLO = 8'b00100000;
  localparam ST_WAIT = 8'b01000000;
  localparam ST_PTRRD = 8'b10000000;

  reg [7:0] state;
  reg [7:0] next_state;
  reg [7:0] addr;
  reg [7:0] hi;
  reg [3:0] cnt;
  reg [3:0] target;
  reg is_loop;
  reg [7:0] disp;
  reg we;
  reg [7:0] waddr;
  reg [7:0] wdata;
  reg [7:0] raddr;
  wire [7:0] rdata;
  wire [7:0] mux_we_addr;

  assign busy_out = (state != ST_IDLE);

  // Ex operand byte maps onto the current working register bank
  function [7:0] wdl_map;
    input [7:0] b;
    input [3:0] rp;
    begin
      wdl_map = (b[7:4] == `WDL_WREG_NIBBLE) ? {rp, b[3:0]} : b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Core writes win only when this block is idle
  wire core_wr = rf_we_in && !busy_out;
  assign mux_we_addr = core_wr ? rf_waddr_in : waddr;

  wdl_regfile u_rf (
    .mclk_in(mclk_in),
    .we_in(core_wr || we),
    .waddr_in(mux_we_addr),
    .wdata_in(core_wr ? rf_wdata_in : wdata),
    .raddr_in(raddr),
    .rdata_out(rdata)
  );

  wire [15:0] word_in = {hi, rdata};
  wire [15:0] word_res = word_in - 16'h0001;
  wire [7:0] cnt_res = rdata - 8'h01;
  wire [15:0] br_pc = next_pc_in + {{8{disp[7]}}, disp};

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = state;
      ST_PTRRD: next_state = ST_PTR;
      ST_PTR: next_state = ST_RDHI;
      ST_RDHI: next_state = is_loop ? ST_WRLO : ST_RDLO;
      ST_RDLO: next_state = ST_WRHI;
      ST_WRHI: next_state = ST_WRLO;
      ST_WRLO: next_state = ST_WAIT;
      ST_WAIT: next_state = (cnt <= 4'd1) ? ST_IDLE : ST_WAIT;
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      addr <= 8'h00;
      hi <= 8'h00;
      cnt <= 4'h0;
      target <= 4'h0;
      is_loop <= 1'b0;
      disp <= 8'h00;
      we <= 1'b0;
      waddr <= 8'h00;
      wdata <= 8'h00;
      raddr <= 8'h00;
      done_out <= 1'b0;
      pc_out <= 16'h0000;
      pc_load_out <= 1'b0;
      flags_out <= `WDL_FLAGS_RESET;
      interrupt_mask_reg_out <= `WDL_IMR_RESET;
      cycles_out <= 4'h0;
      illegal_out <= 1'b0;
    end else begin
      we <= 1'b0;
      done_out <= 1'b0;
      pc_load_out <= 1'b0;
      state <= next_state;
      if (flags_we_in && !busy_out) begin
        flags_out <= flags_in;
      end
      if (imr_we_in && !busy_out) begin
        interrupt_mask_reg_out <= imr_in;
      end
      if (state != ST_IDLE) begin
        cnt <= cnt - 4'd1;
      end
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            is_loop <= 1'b0;
            illegal_out <= 1'b0;
            if (opcode_in == `WDL_OP_WORD_DEC_PAIR) begin
              addr <= wdl_map(operand_in, reg_ptr_in);
              raddr <= wdl_map(operand_in, reg_ptr_in);
              // Take cycle counts as the first of the instruction
              cnt <= `WDL_CYC_WORD_DEC - 4'd1;
              target <= `WDL_CYC_WORD_DEC;
              state <= ST_RDHI;
            end else if (opcode_in == `WDL_OP_WORD_DEC_IND) begin
              raddr <= wdl_map(operand_in, reg_ptr_in);
              cnt <= `WDL_CYC_WORD_DEC - 4'd1;
              target <= `WDL_CYC_WORD_DEC;
              // Pointer byte needs one cycle to leave the registered read port
              state <= ST_PTRRD;
            end else if (opcode_in == `WDL_OP_INT_DISABLE) begin
              // Only the global enable drops; level enables stay armed
              interrupt_mask_reg_out[`WDL_IMR_GLOBAL_BIT] <= 1'b0;
              cnt <= `WDL_CYC_INT_DISABLE - 4'd1;
              target <= `WDL_CYC_INT_DISABLE;
              state <= ST_WAIT;
            end else if (opcode_in[3:0] == `WDL_OP_LOOP_LOW) begin
              is_loop <= 1'b1;
              disp <= operand_in;
              addr <= {reg_ptr_in, opcode_in[7:4]};
              raddr <= {reg_ptr_in, opcode_in[7:4]};
              // Counter outside 04-7F raises illegal_out; the loop still executes there
              illegal_out <= ({reg_ptr_in, opcode_in[7:4]} < 8'h04) ||
                ({reg_ptr_in, opcode_in[7:4]} > 8'h7f);
              cnt <= `WDL_CYC_LOOP_FALL - 4'd1;
              target <= `WDL_CYC_LOOP_FALL;
              state <= ST_RDHI;
            end
          end
        end
        ST_PTRRD: begin
        end
        ST_PTR: begin
          addr <= wdl_map(rdata, reg_ptr_in);
          raddr <= wdl_map(rdata, reg_ptr_in);
        end
        ST_RDHI: begin
          raddr <= addr + 8'h01;
        end
        ST_RDLO: begin
          hi <= rdata;
        end
        ST_WRHI: begin
          we <= 1'b1;
          waddr <= addr;
          wdata <= word_res[15:8];
          hi <= word_res[7:0];
          flags_out[`WDL_FLAG_Z] <= (word_res == 16'h0000);
          flags_out[`WDL_FLAG_S] <= word_res[15];
          flags_out[`WDL_FLAG_V] <= word_in[15] & ~word_res[15];
          // C, H and D bits deliberately left alone
        end
        ST_WRLO: begin
          we <= 1'b1;
          if (is_loop) begin
            // Loop counter write; flags untouched
            waddr <= addr;
            wdata <= cnt_res;
            if (cnt_res != 8'h00) begin
              pc_out <= br_pc;
              pc_load_out <= 1'b1;
              cnt <= cnt + 4'd1;
              target <= `WDL_CYC_LOOP_TAKEN;
            end
          end else begin
            waddr <= addr + 8'h01;
            wdata <= hi;
          end
        end
        ST_WAIT: begin
          if (cnt <= 4'd1) begin
            done_out <= 1'b1;
            cycles_out <= target;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // wdl_exec

/* testbench/wdl_exec_asserts.sv */
// Checker for the word decrement, loop and interrupt disable block
`timescale 1ns/1ps
module wdl_exec_asserts (
  input wire mclk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire [7:0] opcode_in,
  input wire [7:0] operand_in,
  input wire [15:0] next_pc_in,
  input wire busy_out,
  input wire done_out,
  input wire [15:0] pc_out,
  input wire pc_load_out,
  input wire [7:0] flags_out,
  input wire [7:0] interrupt_mask_reg_out,
  input wire [3:0] cycles_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  reg [7:0] disp;
  // Operand port may move on after the take, so keep our own copy
  always @(posedge mclk_in) if (start_in && !busy_out) disp <= operand_in;
  // ----------
  // Properties
  // ----------
  sequence s_dec; start_in && !busy_out && opcode_in[7:1] == 7'h40; endsequence
  sequence s_dis; start_in && !busy_out && opcode_in == 8'h8f; endsequence
  sequence s_loop; start_in && !busy_out && opcode_in[3:0] == 4'ha; endsequence
  property p_dec_cyc; s_dec |-> ##10 done_out && cycles_out == 4'ha; endproperty
  a_dec_cyc: assert property (p_dec_cyc) else $error("word decrement timing");
  property p_dec_keep; s_dec |-> ##10 (flags_out & 8'h8c) == ($past(flags_out, 10) & 8'h8c); endproperty
  a_dec_keep: assert property (p_dec_keep) else $error("carry group changed");
  property p_dis; s_dis |-> ##6 done_out && !interrupt_mask_reg_out[7] && cycles_out == 4'h6; endproperty
  a_dis: assert property (p_dis) else $error("disable result");
  property p_dis_mask; s_dis |-> ##6 (interrupt_mask_reg_out & 8'h7f) == ($past(interrupt_mask_reg_out, 6) & 8'h7f);
  endproperty
  a_dis_mask: assert property (p_dis_mask) else $error("level enables changed");
  property p_dis_flags; s_dis |-> ##6 flags_out == $past(flags_out, 6); endproperty
  a_dis_flags: assert property (p_dis_flags) else $error("flags changed by disable");
  property p_loop_cyc; s_loop |-> (##10 done_out && cycles_out == 4'ha) or (##12 done_out && cycles_out == 4'hc);
  endproperty
  a_loop_cyc: assert property (p_loop_cyc) else $error("loop timing");
  property p_loop_flags; s_loop |-> ##10 flags_out == $past(flags_out, 10); endproperty
  a_loop_flags: assert property (p_loop_flags) else $error("flags changed by loop");
  property p_loop_pc; pc_load_out |-> pc_out == next_pc_in + {{8{disp[7]}}, disp}; endproperty
  a_loop_pc: assert property (p_loop_pc) else $error("branch target");
  property p_taken; pc_load_out |-> ##[1:9] done_out && cycles_out == 4'hc; endproperty
  a_taken: assert property (p_taken) else $error("taken loop end");
endmodule // wdl_exec_asserts

/* testbench/tb.sv */
// Self-checking bench for the word decrement, loop and interrupt disable block
`timescale 1ns/1ps
module tb;
  reg mclk_in = 1'h0, rst_n_in = 1'h0, start_in = 1'h0, rf_we_in = 1'h0, flags_we_in = 1'h0, imr_we_in = 1'h0;
  reg [7:0] opcode_in = 8'h00, operand_in = 8'h00, rf_waddr_in = 8'h00, rf_wdata_in = 8'h00;
  reg [7:0] flags_in = 8'h00, imr_in = 8'h00;
  reg [15:0] next_pc_in = 16'h1000;
  reg [3:0] reg_ptr_in = 4'h1;
  wire busy_out, done_out, pc_load_out, illegal_out;
  wire [15:0] pc_out;
  wire [7:0] flags_out, interrupt_mask_reg_out;
  wire [3:0] cycles_out;
  integer fails = 0, n_tests = 0, cyc = 0;
  reg ld;
  reg [15:0] tgt;
  wdl_exec i_dut (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_in),
    .opcode_in(opcode_in),
    .operand_in(operand_in),
    .next_pc_in(next_pc_in),
    .reg_ptr_in(reg_ptr_in),
    .rf_we_in(rf_we_in),
    .rf_waddr_in(rf_waddr_in),
    .rf_wdata_in(rf_wdata_in),
    .flags_in(flags_in),
    .flags_we_in(flags_we_in),
    .imr_in(imr_in),
    .imr_we_in(imr_we_in),
    .busy_out(busy_out),
    .done_out(done_out),
    .pc_out(pc_out),
    .pc_load_out(pc_load_out),
    .flags_out(flags_out),
    .interrupt_mask_reg_out(interrupt_mask_reg_out),
    .cycles_out(cycles_out),
    .illegal_out(illegal_out)
  );
  always #50 mclk_in = ~mclk_in;
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task pre(input [7:0] f, input [7:0] m);
    flags_in <= f;
    imr_in <= m;
    flags_we_in <= 1'h1;
    imr_we_in <= 1'h1;
    @(posedge mclk_in);
  endtask
  // Write strobe stays up between writes; run lowers it with the start
  task wr(input [7:0] a, input [7:0] d);
    rf_waddr_in <= a;
    rf_wdata_in <= d;
    rf_we_in <= 1'h1;
    @(posedge mclk_in);
  endtask
  task run(input [7:0] op, input [7:0] d);
    integer k;
    rf_we_in <= 1'h0;
    flags_we_in <= 1'h0;
    imr_we_in <= 1'h0;
    opcode_in <= op;
    operand_in <= d;
    start_in <= 1'h1;
    @(posedge mclk_in);
    start_in <= 1'h0;
    ld = 1'h0;
    @(negedge mclk_in);
    chk("busy", busy_out, 16'h1);
    for (k = 0; k < 20 && done_out !== 1'h1; k = k + 1) begin
      @(negedge mclk_in);
      if (pc_load_out === 1'h1) begin
        ld = 1'h1;
        tgt = pc_out;
      end
    end
    chk("done", done_out, 16'h1);
    @(posedge mclk_in);
  endtask
  // ---------
  // Scenarios
  // ---------
  task t_word_dec;
    pre(8'h8c, 8'h8a);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h01);
    wr(8'h14, 8'h30);
    wr(8'h30, 8'h80);
    wr(8'h31, 8'h00);
    run(8'h80, 8'he2);
    chk("flags", flags_out, 16'hcc);
    chk("cycles", cycles_out, 16'ha);
    run(8'h80, 8'he2);
    chk("flags", flags_out, 16'hac);
    run(8'h81, 8'he4);
    chk("flags", flags_out, 16'h9c);
  endtask
  task t_int_dis;
    pre(8'hf4, 8'h8a);
    run(8'h8f, 8'h00);
    chk("mask", interrupt_mask_reg_out, 16'h0a);
    chk("flags", flags_out, 16'hf4);
    chk("cycles", cycles_out, 16'h6);
  endtask
  task t_loop;
    pre(8'h58, 8'h0a);
    wr(8'h15, 8'h03);
    run(8'h5a, 8'h80);
    chk("taken", ld, 16'h1);
    chk("target", tgt, 16'h0f80);
    chk("cycles", cycles_out, 16'hc);
    run(8'h5a, 8'h7f);
    chk("target", tgt, 16'h107f);
    run(8'h5a, 8'hfe);
    chk("fall", {ld, cycles_out}, 16'ha);
    chk("flags", {illegal_out, flags_out}, 16'h58);
    reg_ptr_in <= 4'h0;
    wr(8'h02, 8'h05);
    run(8'h2a, 8'h00);
    chk("range", illegal_out, 16'h1);
  endtask
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      fails = fails + 1;
      conclude;
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    t_word_dec;
    t_int_dis;
    t_loop;
    conclude;
  end
endmodule // tb
bind wdl_exec wdl_exec_asserts i_chk (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .start_in(start_in),
  .opcode_in(opcode_in),
  .operand_in(operand_in),
  .next_pc_in(next_pc_in),
  .busy_out(busy_out),
  .done_out(done_out),
  .pc_out(pc_out),
  .pc_load_out(pc_load_out),
  .flags_out(flags_out),
  .interrupt_mask_reg_out(interrupt_mask_reg_out),
  .cycles_out(cycles_out)
);
